//--- codec_level_mute_control.v
// Level, mute, peak and filter control of a six-DAC, three-ADC codec.
// Assumes samples arrive in the clk domain once per frame, and that the
// frame clock and master clock pins are asynchronous and need syncing.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "codec_level_defines.vh"

// Summary of operation
// - Two-bit select picks the stereo input pair; value 3 means differential.
// - Left, right and mono ADC channels each have an independent mute.
// - Two-bit gain per left and right channel, 0 to 9 dB in 3 dB.
// - Input gain changes apply at once on register write.
// - Each ADC channel's peak output level is held in status.
// - Reading a peak register returns it, then clears it to zero, or to the new sample's level if one arrives in the read cycle.
// - First-order DC-removing high-pass, 3.4 Hz corner at 44.1 kHz.
// - Each of six DACs has its own 1 dB step attenuation register.
// - New attenuation applies at a zero crossing, one detector per channel.
// - Without a zero crossing, change applies after a 512 frame timeout.
// - Per-channel pending flag high on load, low once applied.
// - Bypass bit set makes volume changes apply immediately.
// - Per-DAC mute bits also wait for zero crossing or timeout.
// - When enabled, mute all DACs after 512 zero or -1 frames.
// - Any sample other than zero or -1 unmutes the zero-run mute at once.
// - A disable bit turns the zero-run automatic mute off.
// - Power down when the master clock stops for 10 us.
// - Samples are two's complement, so zero and -1 are easy to detect.
// - Frame clock rate equals sample rate; one frame is one sample.
module codec_level_mute_control (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata,
    input wire frame_clock,
    input wire master_clock_in,
    input wire adc_valid,
    input wire [19:0] adc_left_in,
    input wire [19:0] adc_right_in,
    input wire [19:0] adc_mono_in,
    input wire dac_valid,
    input wire [119:0] dac_samples,
    output reg adc_out_valid,
    output reg [19:0] adc_left_out,
    output reg [19:0] adc_right_out,
    output reg [19:0] adc_mono_out,
    output reg [1:0] input_pair_select,
    output reg differential_mode,
    output reg [1:0] left_input_gain,
    output reg [1:0] right_input_gain,
    output reg [47:0] dac_applied_atten,
    output reg [5:0] dac_applied_silence,
    output reg power_down
);

    // Absolute value of a sample; the most negative code saturates.
    function [19:0] mag;
        input [19:0] s;
        begin
            if (s[19])
                mag = (s == 20'h80000) ? 20'h7FFFF : (~s + 20'h00001);
            else
                mag = s;
        end
    endfunction
    // Zero or -1 code counts as silence.
    function is_quiet;
        input [19:0] s;
        begin
            is_quiet = (s == 20'h00000) || (s == 20'hFFFFF);
        end
    endfunction
    // Clip the filter state back to a 20-bit sample.
    function [19:0] clip;
        input [31:0] acc;
        reg [31:0] whole;
        begin
            whole = {{`HPF_FRAC{acc[31]}}, acc[31:`HPF_FRAC]};
            if (!whole[31] && whole[30:19] != 12'h000)
                clip = 20'h7FFFF;
            else if (whole[31] && whole[30:19] != 12'hFFF)
                clip = 20'h80000;
            else
                clip = whole[19:0];
        end
    endfunction
    // One filter step: y = y1 + (x - x1) - y1 * 2^-11.
    function [31:0] hpf_step;
        input [19:0] x;
        input [19:0] x1;
        input [31:0] y1;
        reg [31:0] dx;
        begin
            dx = {{12{x[19]}}, x} - {{12{x1[19]}}, x1};
            hpf_step = y1 + (dx << `HPF_FRAC)
                - {{`HPF_SHIFT{y1[31]}}, y1[31:`HPF_SHIFT]};
        end
    endfunction
    reg [4:0] adc_ctrl_reg;
    reg [3:0] gain_reg;
    reg [7:0] dac_ctrl_reg;
    reg [7:0] att_reg [0:5];
    reg [7:0] att_live [0:5];
    reg [5:0] mute_live;
    reg [5:0] pending_reg;
    reg [9:0] tmo_cnt [0:5];
    reg [19:0] prev_dac [0:5];
    reg [19:0] peak_reg [0:2];
    reg [19:0] x1_reg [0:2];
    reg [31:0] y1_reg [0:2];
    reg [9:0] zrun_cnt;
    reg zrun_mute;
    reg [1:0] fclk_sync;
    reg fclk_prev;
    reg [1:0] mclk_sync;
    reg mclk_prev;
    reg [9:0] stop_cnt;
    reg [19:0] hpf_out [0:2];
    reg [31:0] y_new [0:2];
    reg [19:0] x_in [0:2];
    reg all_quiet;
    wire frame_tick;
    wire att_sel;
    wire [2:0] att_idx;
    integer i, ri, ai, fi, qi, oi;

    assign frame_tick = fclk_sync[1] & ~fclk_prev;
    assign att_sel = (addr >= `REG_ATT_BASE) && (addr <= `REG_ATT_LAST);
    assign att_idx = addr[4:2] - 3'h4;

    // Frame clock and master clock pins cross in through two flops each.
    always @(posedge clk) begin
        if (!rst_n) begin
            fclk_sync <= 2'h0;
            fclk_prev <= 1'b0;
            mclk_sync <= 2'h0;
            mclk_prev <= 1'b0;
        end else begin
            fclk_sync <= {fclk_sync[0], frame_clock};
            fclk_prev <= fclk_sync[1];
            mclk_sync <= {mclk_sync[0], master_clock_in};
            mclk_prev <= mclk_sync[1];
        end
    end

    // Stopped master clock: no edge for the stop time powers down.
    always @(posedge clk) begin
        if (!rst_n) begin
            stop_cnt <= 10'h000;
            power_down <= 1'b0;
        end else if (mclk_sync[1] != mclk_prev) begin
            stop_cnt <= 10'h000;
            power_down <= 1'b0;
        end else if (stop_cnt >= `CLK_STOP_CYCLES - 1) begin
            power_down <= 1'b1;
        end else begin
            stop_cnt <= stop_cnt + 10'h001;
        end
    end

    // Filter each ADC channel, then zero a muted one; the filter keeps
    // running while muted so an unmute brings no step from stale state.
    always @* begin
        x_in[0] = adc_left_in;
        x_in[1] = adc_right_in;
        x_in[2] = adc_mono_in;
        for (fi = 0; fi < 3; fi = fi + 1) begin
            y_new[fi] = hpf_step(x_in[fi], x1_reg[fi], y1_reg[fi]);
            hpf_out[fi] = adc_ctrl_reg[`MUTE_L_BIT + fi] ? 20'h00000 :
                clip(y_new[fi]);
        end
    end

    // Zero-run detection over all six incoming DAC samples.
    always @* begin
        all_quiet = 1'b1;
        for (qi = 0; qi < `NUM_DAC; qi = qi + 1)
            if (!is_quiet(dac_samples[qi*20 +: 20]))
                all_quiet = 1'b0;
    end

    // Register writes and pin-facing control copies.
    always @(posedge clk) begin
        if (!rst_n) begin
            adc_ctrl_reg <= 5'h00;
            gain_reg <= 4'h0;
            dac_ctrl_reg <= 8'h00;
            input_pair_select <= 2'h0;
            differential_mode <= 1'b0;
            left_input_gain <= 2'h0;
            right_input_gain <= 2'h0;
            for (ri = 0; ri < `NUM_DAC; ri = ri + 1)
                att_reg[ri] <= 8'h00;
        end else begin
            if (wr_stb && addr == `REG_ADC_CTRL)
                adc_ctrl_reg <= wdata[4:0];
            if (wr_stb && addr == `REG_IN_GAIN)
                gain_reg <= wdata[3:0];
            if (wr_stb && addr == `REG_DAC_CTRL)
                dac_ctrl_reg <= wdata[7:0];
            if (wr_stb && att_sel)
                att_reg[att_idx] <= wdata[7:0];
            input_pair_select <= adc_ctrl_reg[`SEL_MSB:`SEL_LSB];
            differential_mode <= 
                (adc_ctrl_reg[`SEL_MSB:`SEL_LSB] == `SEL_DIFF);
            left_input_gain <= gain_reg[`GAIN_L_MSB:`GAIN_L_LSB];
            right_input_gain <= gain_reg[`GAIN_R_MSB:`GAIN_R_LSB];
        end
    end

    // ADC datapath, filter state and peak tracking.
    always @(posedge clk) begin
        if (!rst_n) begin
            adc_out_valid <= 1'b0;
            adc_left_out <= 20'h00000;
            adc_right_out <= 20'h00000;
            adc_mono_out <= 20'h00000;
            for (ai = 0; ai < 3; ai = ai + 1) begin
                x1_reg[ai] <= 20'h00000;
                y1_reg[ai] <= 32'h00000000;
                peak_reg[ai] <= 20'h00000;
            end
        end else begin
            adc_out_valid <= adc_valid;
            if (adc_valid) begin
                adc_left_out <= hpf_out[0];
                adc_right_out <= hpf_out[1];
                adc_mono_out <= hpf_out[2];
            end
            for (ai = 0; ai < 3; ai = ai + 1) begin
                if (adc_valid) begin
                    x1_reg[ai] <= x_in[ai];
                    y1_reg[ai] <= y_new[ai];
                end
                // A new sample in the read cycle survives the clear.
                if (rd_stb && addr == `REG_PEAK_L + {ai[5:0], 2'h0})
                    peak_reg[ai] <= adc_valid ? mag(hpf_out[ai]) : 20'h00000;
                else if (adc_valid && mag(hpf_out[ai]) > peak_reg[ai])
                    peak_reg[ai] <= mag(hpf_out[ai]);
            end
        end
    end

    // Zero-run mute: count quiet frames, release on any live sample.
    always @(posedge clk) begin
        if (!rst_n) begin
            zrun_cnt <= 10'h000;
            zrun_mute <= 1'b0;
        end else if (dac_ctrl_reg[`ZRUN_DIS_BIT]) begin
            zrun_cnt <= 10'h000;
            zrun_mute <= 1'b0;
        end else if (dac_valid) begin
            if (!all_quiet) begin
                zrun_cnt <= 10'h000;
                zrun_mute <= 1'b0;
            end else if (zrun_cnt >= `ZERO_RUN_FRAMES - 10'd1) begin
                zrun_mute <= 1'b1;
            end else begin
                zrun_cnt <= zrun_cnt + 10'h001;
            end
        end
    end

    // Per-channel volume and mute update with zero crossing or timeout.
    // The timeout waits one frame edge past 512, so a full 512 frames pass.
    always @(posedge clk) begin
        if (!rst_n) begin
            pending_reg <= 6'h00;
            mute_live <= 6'h00;
            for (i = 0; i < `NUM_DAC; i = i + 1) begin
                att_live[i] <= 8'h00;
                tmo_cnt[i] <= 10'h000;
                prev_dac[i] <= 20'h00000;
            end
        end else begin
            for (i = 0; i < `NUM_DAC; i = i + 1) begin
                if (dac_valid)
                    prev_dac[i] <= dac_samples[i*20 +: 20];
                if (dac_ctrl_reg[`BYPASS_BIT] ||
                    (att_live[i] == att_reg[i] &&
                     mute_live[i] == dac_ctrl_reg[i])) begin
                    // Nothing waiting, or bypass applies at once.
                    att_live[i] <= att_reg[i];
                    mute_live[i] <= dac_ctrl_reg[i];
                    pending_reg[i] <= 1'b0;
                    tmo_cnt[i] <= 10'h000;
                end else if ((dac_valid &&
                    (dac_samples[i*20 +: 20] == 20'h00000 ||
                    dac_samples[i*20 + 19] != prev_dac[i][19])) ||
                    tmo_cnt[i] > `FRAME_TIMEOUT) begin
                    att_live[i] <= att_reg[i];
                    mute_live[i] <= dac_ctrl_reg[i];
                    pending_reg[i] <= 1'b0;
                    tmo_cnt[i] <= 10'h000;
                end else begin
                    pending_reg[i] <= 1'b1;
                    if (frame_tick)
                        tmo_cnt[i] <= tmo_cnt[i] + 10'h001;
                end
            end
        end
    end

    // Applied levels and mutes to the output stage.
    always @(posedge clk) begin
        if (!rst_n) begin
            dac_applied_atten <= 48'h000000000000;
            dac_applied_silence <= 6'h00;
        end else begin
            for (oi = 0; oi < `NUM_DAC; oi = oi + 1)
                dac_applied_atten[oi*8 +: 8] <= att_live[oi];
            dac_applied_silence <= mute_live | {6{zrun_mute}};
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always @(posedge clk) begin
        if (!rst_n || !rd_stb) begin
            rdata <= 32'h00000000;
        end else if (att_sel) begin
            rdata <= {24'h000000, att_reg[att_idx]};
        end else begin
            case (addr)
                `REG_ADC_CTRL: rdata <= {27'h0000000, adc_ctrl_reg};
                `REG_IN_GAIN: rdata <= {28'h0000000, gain_reg};
                `REG_DAC_CTRL: rdata <= {24'h000000, dac_ctrl_reg};
                `REG_DAC_STAT:
                    rdata <= {24'h000000, power_down, zrun_mute,
                        pending_reg};
                `REG_PEAK_L: rdata <= {12'h000, peak_reg[0]};
                `REG_PEAK_R: rdata <= {12'h000, peak_reg[1]};
                `REG_PEAK_M: rdata <= {12'h000, peak_reg[2]};
                default: rdata <= 32'h00000000;
            endcase
        end
    end
endmodule

//--- codec_level_defines.vh
// Constants of the codec level and mute control block.
// Assumes it is included by bare name from the block's design file.
`ifndef CODEC_LEVEL_DEFINES_VH
`define CODEC_LEVEL_DEFINES_VH

// Register offsets, byte addresses on the plain register port.
`define REG_ADC_CTRL 8'h00
`define REG_IN_GAIN 8'h04
`define REG_DAC_CTRL 8'h08
`define REG_DAC_STAT 8'h0C
`define REG_ATT_BASE 8'h10
`define REG_ATT_LAST 8'h24
`define REG_PEAK_L 8'h28
`define REG_PEAK_R 8'h2C
`define REG_PEAK_M 8'h30

// ADC control fields.
`define SEL_LSB 0
`define SEL_MSB 1
`define SEL_DIFF 2'h3
`define MUTE_L_BIT 2
`define MUTE_R_BIT 3
`define MUTE_M_BIT 4

// Input gain fields, 3 dB per step.
`define GAIN_L_LSB 0
`define GAIN_L_MSB 1
`define GAIN_R_LSB 2
`define GAIN_R_MSB 3

// DAC control and status fields.
`define DAC_MUTE_MSB 5
`define BYPASS_BIT 6
`define ZRUN_DIS_BIT 7
`define STAT_ZRUN_BIT 6
`define STAT_PDN_BIT 7

// Sample and level widths.
`define SAMPLE_W 20
`define ATT_W 8
`define NUM_DAC 6

// High-pass filter: pole at 1 - 2^-11, 12 fraction bits in the state.
`define HPF_SHIFT 11
`define HPF_FRAC 12

// Frame timeouts.
`define FRAME_TIMEOUT 10'd512
`define ZERO_RUN_FRAMES 10'd512

// Master clock stop detection.
`define CLK_PERIOD_NS 20
`define CLK_STOP_NS 10000
`define CLK_STOP_CYCLES (`CLK_STOP_NS / `CLK_PERIOD_NS)

`endif

//--- codec_level_mute_control_chk.sv
// Port checker of the codec level and mute control block.
// Assumes one clk domain and the block's register map; bound below.
`timescale 1ns/10ps
module codec_level_mute_control_chk (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata,
    input wire master_clock_in,
    input wire adc_valid,
    input wire dac_valid,
    input wire [119:0] dac_samples,
    input wire [19:0] adc_left_out,
    input wire [1:0] input_pair_select,
    input wire differential_mode,
    input wire [1:0] left_input_gain,
    input wire [47:0] dac_applied_atten,
    input wire [5:0] dac_applied_silence,
    input wire power_down
);
    reg [7:0] ctl_q;
    reg [7:0] att0_q;
    reg amute_q;
    reg mclk_q;
    reg [9:0] idle_q;
    reg [9:0] run_q;
    wire quiet;
    // A word is quiet when all its bits agree: zero or minus one.
    function automatic logic is_quiet(input logic [119:0] d);
        is_quiet = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (|d[i*20 +: 20] && !(&d[i*20 +: 20])) is_quiet = 1'b0;
        end
    endfunction
    assign quiet = is_quiet(dac_samples);
    // Shadow the control bits, count idle master clock and quiet frames.
    always @(posedge clk) begin
        mclk_q <= master_clock_in;
        if (!rst_n) begin
            ctl_q <= 8'h00;
            att0_q <= 8'h00;
            amute_q <= 1'b0;
            idle_q <= 10'h000;
            run_q <= 10'h000;
        end else begin
            if (wr_stb && addr == 8'h08) ctl_q <= wdata[7:0];
            if (wr_stb && addr == 8'h10) att0_q <= wdata[7:0];
            if (wr_stb && addr == 8'h00) amute_q <= wdata[2];
            if (master_clock_in != mclk_q) idle_q <= 10'h000;
            else if (idle_q != 10'h3FF) idle_q <= idle_q + 10'h001;
            // Saturating, so a very long silence cannot wrap the count.
            if (ctl_q[7]) run_q <= 10'h000;
            else if (dac_valid)
                run_q <= quiet ? run_q + (run_q != 10'h3FF) : 10'h000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_diff;
        differential_mode == (input_pair_select == 2'h3);
    endproperty
    a_diff: assert property (p_diff) else $error("diff mode wrong");
    property p_gain;
        wr_stb && addr == 8'h04 |-> ##2 left_input_gain == $past(wdata[1:0], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain late");
    property p_mute;
        adc_valid && amute_q |=> adc_left_out == 20'h00000;
    endproperty
    a_mute: assert property (p_mute) else $error("left not muted");
    property p_peak_clr;
        (rd_stb && addr == 8'h2C && !adc_valid) ##1
        (rd_stb && addr == 8'h2C && !adc_valid) |=> rdata == 32'h0;
    endproperty
    a_peak_clr: assert property (p_peak_clr) else $error("peak kept");
    property p_byp;
        wr_stb && addr == 8'h10 && ctl_q[6] |->
        ##[2:3] dac_applied_atten[7:0] == att0_q;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass slow");
    property p_pdn_rise;
        $rose(power_down) |-> idle_q >= 10'd500 && idle_q <= 10'd510;
    endproperty
    a_pdn_rise: assert property (p_pdn_rise) else $error("pdn time");
    property p_zrun;
        dac_valid && quiet && run_q == 10'd511 && !ctl_q[7] |->
        ##[1:3] dac_applied_silence == 6'h3F;
    endproperty
    a_zrun: assert property (p_zrun) else $error("no zero mute");
    property p_unmute;
        dac_valid && !quiet && ctl_q[5:0] == 6'h00 |->
        ##2 dac_applied_silence == 6'h00;
    endproperty
    a_unmute: assert property (p_unmute) else $error("no unmute");
endmodule
bind codec_level_mute_control codec_level_mute_control_chk u_chk (
    .clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .master_clock_in,
    .adc_valid, .dac_valid, .dac_samples, .adc_left_out, .input_pair_select,
    .differential_mode, .left_input_gain, .dac_applied_atten,
    .dac_applied_silence, .power_down);

//--- codec_source_model.sv
// Far side model: frame clock and master clock of the audio source.
// Assumes the bench clk; the master clock stops on command.
`timescale 1ns/10ps
module codec_source_model (
    input wire clk,
    input wire mclk_run,
    output reg frame_clock,
    output reg master_clock_in
);
    reg [1:0] div_q = 2'h0;
    initial frame_clock = 1'b0;
    initial master_clock_in = 1'b0;
    // Both clocks come from one source; a stopped clock holds its level.
    always @(posedge clk) begin
        if (mclk_run) master_clock_in <= !master_clock_in;
        div_q <= div_q + 2'h1;
        // Eight clk cycles per frame, one sample per frame.
        if (div_q == 2'h3) frame_clock <= !frame_clock;
    end
endmodule

//--- test_codec_level_mute_control.sv
// Self-checking bench of the codec level and mute control block.
// Assumes the source model for clocks; the bench is host and DSP.
`timescale 1ns/10ps
module test_codec_level_mute_control;
    reg clk, rst_n, wr_stb, rd_stb, adc_valid, dac_valid, mclk_run;
    reg [7:0] addr;
    reg [31:0] wdata;
    reg [19:0] l_in, r_in, m_in;
    reg [119:0] dac_s;
    wire [31:0] rdata;
    wire fclk, mclk, aov, diff, pdn;
    wire [19:0] l_out, r_out, m_out;
    wire [1:0] sel, gl, gr;
    wire [47:0] att;
    wire [5:0] sil;
    integer fails, n_compared, i;
    // Rows: {pair select, right gain, left gain, differential}.
    reg [6:0] rows [0:3] = '{7'h18, 7'h32, 7'h4C, 7'h67};
    codec_level_mute_control u_codec_level_mute_control (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .frame_clock(fclk), .master_clock_in(mclk), .adc_valid(adc_valid),
        .adc_left_in(l_in), .adc_right_in(r_in), .adc_mono_in(m_in),
        .dac_valid(dac_valid), .dac_samples(dac_s), .adc_out_valid(aov),
        .adc_left_out(l_out), .adc_right_out(r_out), .adc_mono_out(m_out),
        .input_pair_select(sel), .differential_mode(diff),
        .left_input_gain(gl), .right_input_gain(gr),
        .dac_applied_atten(att), .dac_applied_silence(sil), .power_down(pdn));
    codec_source_model u_codec_source_model (.clk(clk), .mclk_run(mclk_run),
        .frame_clock(fclk), .master_clock_in(mclk));
    task chk(input string what, input [47:0] exp, input [47:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            $display("wrong value %s exp %h got %h", what, exp, got);
            fails = fails + 1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input [7:0] a, input [31:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(what, e, rdata);
    endtask
    task adc(input [19:0] l, input [19:0] r, input [19:0] m);
        @(posedge clk);
        adc_valid <= 1'b1;
        {l_in, r_in, m_in} <= {l, r, m};
        @(posedge clk);
        adc_valid <= 1'b0;
        #1;
    endtask
    // One sample set per frame of eight cycles.
    task dac(input [119:0] s);
        @(posedge clk);
        dac_valid <= 1'b1;
        dac_s <= s;
        @(posedge clk);
        dac_valid <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    // The run needs about 13400 cycles; a hang is cut off well after.
    initial begin
        repeat (40000) @(posedge clk);
        fails = fails + 1;
        wrap_up;
    end
    initial begin
        {fails, n_compared, rst_n, wr_stb, rd_stb, adc_valid} = 0;
        {dac_valid, addr, wdata, l_in, r_in, m_in, dac_s} = 0;
        mclk_run = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset", 48'h0, {sel, diff, gl, gr, pdn, sil, l_out});
        chk("reset att", 48'h0, att);
        for (i = 0; i < 4; i++) begin
            wr(8'h00, {30'h0, rows[i][6:5]});
            wr(8'h04, {28'h0, rows[i][4:1]});
            repeat (3) @(posedge clk);
            #1;
            chk("pair", {rows[i][6:5], rows[i][0]}, {sel, diff});
            chk("gain", rows[i][4:1], {gr, gl});
        end
        wr(8'h00, 32'h4);
        adc(20'h01000, 20'h01000, 20'hFFED4);
        chk("adc left", {1'b1, 20'h0}, {aov, l_out});
        chk("adc", {20'h01000, 20'hFFED4}, {r_out, m_out});
        adc(20'h01000, 20'h01000, 20'hFFED4);
        chk("hpf", 20'h00FFE, r_out);
        @(posedge clk);
        addr <= 8'h2C;
        rd_stb <= 1'b1;
        @(posedge clk);
        #1;
        chk("peak", 32'h1000, rdata);
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("peak clear", 32'h0, rdata);
        rd(8'h30, 32'h12C, "peak mono");
        rd(8'h28, 32'h0, "peak left");
        rd(8'hFC, 32'h0, "unmapped");
        dac({6{20'h00064}});
        wr(8'h10, 32'h5);
        repeat (3) @(posedge clk);
        rd(8'h0C, 32'h1, "pending");
        dac({6{20'h00064}});
        chk("hold", 48'h0, att);
        dac({{5{20'h00064}}, 20'hFFF9C});
        chk("apply", 48'h5, att);
        rd(8'h0C, 32'h0, "done");
        wr(8'h08, 32'h02);
        wr(8'h14, 32'h7);
        repeat (3900) @(posedge clk);
        #1;
        chk("wait", 14'h0, {att[15:8], sil});
        repeat (600) @(posedge clk);
        chk("timeout", {8'h07, 6'h02}, {att[15:8], sil});
        wr(8'h08, 32'h42);
        wr(8'h10, 32'h9);
        repeat (4) @(posedge clk);
        #1;
        chk("bypass", 8'h09, att[7:0]);
        wr(8'h08, 32'h00);
        for (i = 0; i < 511; i++) dac(i[0] ? {6{20'hFFFFF}} : 120'h0);
        chk("run 511", 6'h00, sil);
        dac(120'h0);
        chk("run 512", 6'h3F, sil);
        rd(8'h0C, 32'h40, "run flag");
        dac({60'h0, 20'h00005, 40'h0});
        chk("unmute", 6'h00, sil);
        wr(8'h08, 32'h80);
        for (i = 0; i < 520; i++) dac(120'h0);
        chk("run off", 6'h00, sil);
        @(posedge clk);
        mclk_run <= 1'b0;
        repeat (480) @(posedge clk);
        #1;
        chk("clock idle", 1'b0, pdn);
        repeat (40) @(posedge clk);
        chk("power down", 1'b1, pdn);
        rd(8'h0C, 32'h80, "pdn flag");
        @(posedge clk);
        mclk_run <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("wake", 1'b0, pdn);
        wrap_up;
    end
endmodule
